// [src/swout_pkg.sv]
`default_nettype none
package swout_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // delay timebase: 0.1 s per tick
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 22;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  // delay settings in ticks, 0..1000 (0.0 .. 100.0 s)
  localparam int unsigned DELAY_W = 10;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 10'h3e8;
  localparam logic [DELAY_W-1:0] DELAY_RST = 10'h000;
  localparam int unsigned PV_W = 32;

  typedef enum logic [2:0] {
    FN_OFF, FN_ON, FN_DIAG, FN_LIMIT, FN_DIGITAL
  } func_t;

  typedef enum logic [1:0] {
    EV_ALARM, EV_ALARM_OR_WARN, EV_WARN
  } evclass_t;

  typedef enum logic [1:0] {
    SRC_NONE, SRC_AD1, SRC_AD2
  } dsrc_t;

  typedef enum logic [2:0] {
    PV_NONE, PV_LEVEL, PV_DISTANCE, PV_VOLTAGE, PV_TEMP, PV_ECHO_AMP
  } pvsel_t;

  typedef enum logic [1:0] {
    FAIL_ACTUAL, FAIL_OPEN, FAIL_CLOSED
  } failmode_t;
endpackage
`default_nettype wire

// [src/tick_divider.sv]
`default_nettype none
module tick_divider (
  input wire logic CLOCK,
  input wire logic NRST,
  output logic tick
);
  import swout_pkg::*;
  logic [TICK_W-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = (cnt_q == TICK_LAST) ? '0 : cnt_q + 1'b1;
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == TICK_LAST);
endmodule
`default_nettype wire

// [src/sync2.sv]
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q, s2_q;
  // first stage feeds only the second stage
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule
`default_nettype wire

// [src/switch_output_controller.sv]
// What this block does
// - function off keeps the output open always unless inverted, then closed
// - function on keeps the output closed always unless inverted, then open
// - off and on serve to simulate the output independent of process
// - diagnostic mode: closed, open only while selected event class present
// - event class: alarm only, alarm or warning, warning only
// - digital mode: output follows the selected digital block value
// - digital source: none, advanced diagnostic block 1 or 2
// - limit mode compares one selected process variable; none disables
// - on above off: close above on value, open below off value
// - on below off: close below on value, open above off value
// - limit mode waits a switch-on delay of 0 to 100 s
// - limit mode waits a separate switch-off delay of 0 to 100 s
// - in limit or digital mode an error keeps, opens or closes output
// - inversion swaps open and closed, otherwise output as computed
// - readback shows present open or closed state
`default_nettype none
module switch_output_controller (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire swout_pkg::func_t FUNC_SEL,
  input wire swout_pkg::evclass_t EVENT_CLASS,
  input wire swout_pkg::dsrc_t DIGITAL_SRC,
  input wire swout_pkg::pvsel_t PV_SEL,
  input wire swout_pkg::failmode_t FAIL_MODE,
  input wire logic INVERT,
  input wire logic signed [swout_pkg::PV_W-1:0] ON_VALUE,
  input wire logic signed [swout_pkg::PV_W-1:0] OFF_VALUE,
  input wire logic [swout_pkg::DELAY_W-1:0] ON_DELAY,
  input wire logic [swout_pkg::DELAY_W-1:0] OFF_DELAY,
  input wire logic signed [swout_pkg::PV_W-1:0] PV_LEVEL_IN,
  input wire logic signed [swout_pkg::PV_W-1:0] PV_DISTANCE_IN,
  input wire logic signed [swout_pkg::PV_W-1:0] PV_VOLTAGE_IN,
  input wire logic signed [swout_pkg::PV_W-1:0] PV_TEMP_IN,
  input wire logic signed [swout_pkg::PV_W-1:0] PV_ECHO_AMP_IN,
  input wire logic ALARM_EVENT,
  input wire logic WARN_EVENT,
  input wire logic ERROR,
  input wire logic AD1_OUT,
  input wire logic AD2_OUT,
  output logic SWITCH_CLOSED,
  output logic SWITCH_STATUS
);
  import swout_pkg::*;

  logic tick;
  logic [2:0] ev_s;
  logic alarm_s, warn_s, error_s;
  logic [1:0] ad_s;
  logic ad1_s, ad2_s;

  tick_divider u_tick (
    .CLOCK(CLOCK),
    .NRST(NRST),
    .tick(tick)
  );

  // events and block outputs may come from elsewhere; synchronise them
  sync2 #(.W(5)) u_sync (
    .CLOCK(CLOCK),
    .NRST(NRST),
    .d({ALARM_EVENT, WARN_EVENT, ERROR, AD1_OUT, AD2_OUT}),
    .q({ev_s, ad_s})
  );
  assign alarm_s = ev_s[2];
  assign warn_s = ev_s[1];
  assign error_s = ev_s[0];
  assign ad1_s = ad_s[1];
  assign ad2_s = ad_s[0];

  // clamp a delay setting to its documented range
  function automatic logic [DELAY_W-1:0] clamp_delay(input logic [DELAY_W-1:0] v);
    return (v > DELAY_MAX) ? DELAY_MAX : v;
  endfunction

  // event presence for the chosen class
  logic diag_evt;
  always_comb begin
    case (EVENT_CLASS)
      EV_ALARM: diag_evt = alarm_s;
      EV_ALARM_OR_WARN: diag_evt = alarm_s | warn_s;
      EV_WARN: diag_evt = warn_s;
      default: diag_evt = 1'b0;
    endcase
  end

  logic dig_val;
  always_comb begin
    case (DIGITAL_SRC)
      SRC_AD1: dig_val = ad1_s;
      SRC_AD2: dig_val = ad2_s;
      default: dig_val = 1'b0;
    endcase
  end

  logic signed [PV_W-1:0] pv;
  logic pv_en;
  always_comb begin
    pv_en = 1'b1;
    case (PV_SEL)
      PV_LEVEL: pv = PV_LEVEL_IN;
      PV_DISTANCE: pv = PV_DISTANCE_IN;
      PV_VOLTAGE: pv = PV_VOLTAGE_IN;
      PV_TEMP: pv = PV_TEMP_IN;
      PV_ECHO_AMP: pv = PV_ECHO_AMP_IN;
      default: begin
        pv = '0;
        pv_en = 1'b0;
      end
    endcase
  end

  // hysteresis: want_on/want_off are the raw threshold conditions
  logic want_on, want_off;
  always_comb begin
    if (ON_VALUE > OFF_VALUE) begin
      want_on = pv > ON_VALUE;
      want_off = pv < OFF_VALUE;
    end else begin
      want_on = pv < ON_VALUE;
      want_off = pv > OFF_VALUE;
    end
  end

  // limit state with delays; holds between thresholds
  // the tick runs free, so a delay may end up to one tick early
  logic lim_q, lim_d;
  logic [DELAY_W-1:0] dly_q, dly_d;
  logic limit_active;
  assign limit_active = (FUNC_SEL == FN_LIMIT) && pv_en;

  always_comb begin
    lim_d = lim_q;
    dly_d = dly_q;
    if (!limit_active) begin
      // leaving limit mode drops any pending delay
      dly_d = '0;
    end else if (!lim_q && want_on) begin
      if (dly_q >= clamp_delay(ON_DELAY)) begin
        lim_d = 1'b1;
        dly_d = '0;
      end else if (tick) begin
        dly_d = dly_q + 1'b1;
      end
    end else if (lim_q && want_off) begin
      if (dly_q >= clamp_delay(OFF_DELAY)) begin
        lim_d = 1'b0;
        dly_d = '0;
      end else if (tick) begin
        dly_d = dly_q + 1'b1;
      end
    end else begin
      dly_d = '0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      lim_q <= 1'b0;
      dly_q <= DELAY_RST;
    end else begin
      lim_q <= lim_d;
      dly_q <= dly_d;
    end
  end

  // mode select and error override, then inversion last
  logic comp, ovr, out_d, out_q;
  always_comb begin
    case (FUNC_SEL)
      FN_OFF: comp = 1'b0;
      FN_ON: comp = 1'b1;
      FN_DIAG: comp = !diag_evt;
      FN_LIMIT: comp = pv_en && lim_q;
      FN_DIGITAL: comp = dig_val;
      default: comp = 1'b0;
    endcase
    ovr = comp;
    if (error_s && (FUNC_SEL == FN_LIMIT || FUNC_SEL == FN_DIGITAL)) begin
      case (FAIL_MODE)
        FAIL_OPEN: ovr = 1'b0;
        FAIL_CLOSED: ovr = 1'b1;
        default: ovr = comp;
      endcase
    end
    out_d = ovr ^ INVERT;
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign SWITCH_CLOSED = out_q;
  assign SWITCH_STATUS = out_q;

  a_forced_open: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_OFF && !INVERT) |=> !SWITCH_CLOSED)
    else $error("off mode did not open output");
  a_forced_closed: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_ON && !INVERT) |=> SWITCH_CLOSED)
    else $error("on mode did not close output");
  a_diag_open: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIAG && EVENT_CLASS == EV_ALARM && alarm_s && !INVERT)
    |=> !SWITCH_CLOSED)
    else $error("diag event did not open output");
  a_diag_warn_only: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIAG && EVENT_CLASS == EV_WARN && !warn_s && !INVERT)
    |=> SWITCH_CLOSED)
    else $error("warn class reacted to other event");
  a_digital_follow: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIGITAL && DIGITAL_SRC == SRC_AD2 && !error_s && !INVERT)
    |=> SWITCH_CLOSED == $past(ad2_s))
    else $error("digital mode did not follow block");
  a_pv_none: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_LIMIT && PV_SEL == PV_NONE && !error_s && !INVERT)
    |=> !SWITCH_CLOSED)
    else $error("limit with no variable closed output");
  a_delay_range: assert property (@(posedge CLOCK) disable iff (!NRST)
    dly_q <= DELAY_MAX)
    else $error("delay timer past range");
  a_delay_cancel: assert property (@(posedge CLOCK) disable iff (!NRST)
    (limit_active && !lim_q && !want_on && !want_off) |=> dly_q == '0)
    else $error("pending delay not cleared");
  a_fail_open: assert property (@(posedge CLOCK) disable iff (!NRST)
    (error_s && FUNC_SEL == FN_DIGITAL && FAIL_MODE == FAIL_OPEN)
    |=> SWITCH_CLOSED == $past(INVERT))
    else $error("failure open not applied");
  a_invert_swap: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_ON && INVERT) |=> !SWITCH_CLOSED)
    else $error("inversion not applied");

  // helper terms for the limit checks only
  logic on_due, off_due;
  assign on_due = dly_q >= clamp_delay(ON_DELAY);
  assign off_due = dly_q >= clamp_delay(OFF_DELAY);

  // limit steps: the condition meets its delay, then the state moves
  sequence s_close_due;
    limit_active && !lim_q && want_on && on_due;
  endsequence
  sequence s_open_due;
    limit_active && lim_q && want_off && off_due;
  endsequence
  sequence s_close_pending;
    limit_active && !lim_q && want_on && !on_due;
  endsequence
  sequence s_open_pending;
    limit_active && lim_q && want_off && !off_due;
  endsequence
  sequence s_between;
    limit_active && !want_on && !want_off;
  endsequence

  a_close_due: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_close_due |=> lim_q)
    else $error("limit state did not close when due");
  a_open_due: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_open_due |=> !lim_q)
    else $error("limit state did not open when due");
  a_close_wait: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_close_pending |=> !lim_q)
    else $error("limit state closed before its delay");
  a_open_wait: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_open_pending |=> lim_q)
    else $error("limit state opened before its delay");
  a_hyst_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    s_between |=> lim_q == $past(lim_q))
    else $error("limit state moved between thresholds");
  a_timer_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    (limit_active && !tick
      && ((!lim_q && want_on && !on_due) || (lim_q && want_off && !off_due)))
    |=> dly_q == $past(dly_q))
    else $error("delay timer moved without a tick");
  a_cancel_closed: assert property (@(posedge CLOCK) disable iff (!NRST)
    (limit_active && lim_q && !want_off) |=> dly_q == '0)
    else $error("pending off delay not cleared");
  a_limit_drive: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_LIMIT && pv_en && !error_s && !INVERT)
    |=> SWITCH_CLOSED == $past(lim_q))
    else $error("limit mode did not drive limit state");
  a_digital_ad1: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIGITAL && DIGITAL_SRC == SRC_AD1 && !error_s && !INVERT)
    |=> SWITCH_CLOSED == $past(ad1_s))
    else $error("digital mode did not follow first block");
  a_source_none: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIGITAL && DIGITAL_SRC == SRC_NONE && !error_s && !INVERT)
    |=> !SWITCH_CLOSED)
    else $error("no digital source closed output");
  a_alarm_only: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIAG && EVENT_CLASS == EV_ALARM && !alarm_s && !INVERT)
    |=> SWITCH_CLOSED)
    else $error("alarm class reacted to other event");
  a_invert_last: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIGITAL && error_s && FAIL_MODE == FAIL_CLOSED && INVERT)
    |=> !SWITCH_CLOSED)
    else $error("inversion not applied after override");
  a_error_ignored: assert property (@(posedge CLOCK) disable iff (!NRST)
    (FUNC_SEL == FN_DIAG && error_s && EVENT_CLASS == EV_WARN && !warn_s && !INVERT)
    |=> SWITCH_CLOSED)
    else $error("error acted outside limit or digital mode");
endmodule
`default_nettype wire

// [bench/load_model.sv]
`default_nettype none
module load_model (
  input wire logic CLOCK,
  input wire logic contact_closed,
  output logic load_energised
);
  timeunit 1ns;
  timeprecision 1ns;
  // relay coil: pulls in one clock after the contact closes
  always_ff @(posedge CLOCK) begin
    load_energised <= contact_closed;
  end
endmodule
`default_nettype wire

// [bench/switch_output_controller_tb_top.sv]
`default_nettype none
module switch_output_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import swout_pkg::*;
  logic clock, nrst, invert, alarm, warn, err, ad1, ad2, load, sw, st, exp_v;
  func_t fsel;
  evclass_t ecls;
  dsrc_t dsrc;
  pvsel_t psel;
  failmode_t fmode;
  logic signed [PV_W-1:0] on_v, off_v;
  logic signed [PV_W-1:0] pv [5];
  logic [DELAY_W-1:0] on_d, off_d;
  logic q [$];
  int n_fail, samples_checked, seed;
  event chk;

  switch_output_controller switch_output_controller_inst (.CLOCK(clock), .NRST(nrst),
    .FUNC_SEL(fsel), .EVENT_CLASS(ecls), .DIGITAL_SRC(dsrc), .PV_SEL(psel),
    .FAIL_MODE(fmode), .INVERT(invert), .ON_VALUE(on_v), .OFF_VALUE(off_v),
    .ON_DELAY(on_d), .OFF_DELAY(off_d), .PV_LEVEL_IN(pv[0]), .PV_DISTANCE_IN(pv[1]),
    .PV_VOLTAGE_IN(pv[2]), .PV_TEMP_IN(pv[3]), .PV_ECHO_AMP_IN(pv[4]),
    .ALARM_EVENT(alarm), .WARN_EVENT(warn), .ERROR(err), .AD1_OUT(ad1), .AD2_OUT(ad2),
    .SWITCH_CLOSED(sw), .SWITCH_STATUS(st));
  load_model load_model_inst (.CLOCK(clock), .contact_closed(sw), .load_energised(load));

  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end

  task final_report;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // 4 edges cover the 3-edge synchroniser path plus the load's one-edge lag
  task step(input logic e);
    repeat (4) @(posedge clock);
    @(negedge clock);
    q.push_back(e);
    -> chk;
  endtask

  always begin
    @(chk);
    exp_v = q.pop_front();
    samples_checked++;
    if (sw !== exp_v || st !== exp_v || load !== exp_v) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp %b got %b status %b load %b",
        $time, exp_v, sw, st, load);
    end
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    final_report;
  end

  initial begin
    seed = 98;
    nrst = 0;
    {invert, alarm, warn, err, ad1, ad2} = '0;
    fsel = FN_OFF;
    ecls = EV_ALARM;
    dsrc = SRC_NONE;
    psel = PV_NONE;
    fmode = FAIL_ACTUAL;
    {on_v, off_v, on_d, off_d} = '0;
    foreach (pv[i]) pv[i] = '0;
    repeat (5) @(negedge clock);
    nrst = 1;
    err = 1;
    step(1'b0);
    fsel = FN_ON;
    step(1'b1);
    invert = 1;
    step(1'b0);
    $display("forced test done");
    invert = 0;
    // error stays up: diagnostic mode must ignore it
    fsel = FN_DIAG;
    for (int c = 0; c < 3; c++) for (int k = 0; k < 4; k++) begin
      ecls = evclass_t'(c);
      {alarm, warn} = 2'(k);
      step(!(c == 0 ? alarm : c == 2 ? warn : alarm | warn));
    end
    $display("diagnostic test done");
    {alarm, warn} = 2'b00;
    err = 0;
    fsel = FN_DIGITAL;
    for (int k = 0; k < 12; k++) begin
      dsrc = dsrc_t'(k / 4);
      {ad1, ad2} = 2'(k);
      step(dsrc == SRC_AD1 ? ad1 : dsrc == SRC_AD2 ? ad2 : 1'b0);
    end
    err = 1;
    for (int k = 0; k < 3; k++) begin
      fmode = failmode_t'(k);
      step(k != 1);
    end
    invert = 1;
    step(1'b0);
    {invert, err} = 2'b00;
    $display("digital test done");
    fsel = FN_LIMIT;
    on_v = 100;
    off_v = 50;
    for (int p = 1; p < 6; p++) begin
      psel = pvsel_t'(p);
      // unselected variables get noise; only the chosen one may matter
      foreach (pv[i]) pv[i] = $random(seed);
      pv[p-1] = 120;
      step(1'b1);
      pv[p-1] = 70;
      step(1'b1);
      pv[p-1] = 40;
      step(1'b0);
    end
    on_v = 50;
    off_v = 100;
    step(1'b1);
    pv[4] = 70;
    step(1'b1);
    pv[4] = 120;
    step(1'b0);
    pv[4] = 40;
    step(1'b1);
    fmode = FAIL_OPEN;
    err = 1;
    step(1'b0);
    err = 0;
    psel = PV_NONE;
    step(1'b0);
    psel = PV_ECHO_AMP;
    pv[4] = 120;
    on_d = 1;
    step(1'b0);
    pv[4] = 40;
    repeat (10) @(negedge clock);
    step(1'b0);
    on_d = 0;
    step(1'b1);
    off_d = 1;
    pv[4] = 120;
    step(1'b1);
    pv[4] = 70;
    step(1'b1);
    $display("limit test done");
    // mid-run reset: output opens and the limit state restarts open
    nrst = 0;
    step(1'b0);
    nrst = 1;
    step(1'b0);
    pv[4] = 40;
    step(1'b1);
    $display("reset test done");
    final_report;
  end
endmodule
`default_nettype wire
